// ---- hw/spi_tunnel_pkg.sv ----
// Constants for the serial peripheral control, pin routing and interrupt registers.
// Assumes a 32-bit AXI4-Lite register bus with one register in the low byte of each aligned word.
//
// Contract
// - Select value 2 uses second address pin
// - Bit 5 picks main or subordinate target
// - Node id bits 3:0, ignored when main
// - Bits 6,5,4 enable master selects 2,1,0
// - Bit 3 drives busy onto a pin
// - Bits 2:0 choose busy pin 0 to 7
// - Pending underflow bit 6, overflow bit 5
// - Pending bad command bit 4, tunnel bit 3
// - Remote bits 2,1 raised only as master
// - Mask register gates pending interrupts
// - Bit 0 done; mask bits match positions
// - Mask bits 6,5 read back as written
// - Routed busy follows status busy bit 0 one cycle later
package spi_tunnel_pkg;

  localparam int AXI_ADDR_W = 12;
  localparam int AXI_DATA_W = 32;
  localparam int REG_W      = 8;
  localparam int IRQ_W      = 7;
  localparam int GPIO_N     = 8;

  localparam logic [7:0] IDX_STATUS   = 8'hB1;
  localparam logic [7:0] IDX_TARGET   = 8'hB4;
  localparam logic [7:0] IDX_PINCFG   = 8'hB5;
  localparam logic [7:0] IDX_PENDING  = 8'hB6;
  localparam logic [7:0] IDX_IRQMASK  = 8'hB7;

  localparam logic [7:0] TARGET_RESET  = 8'h00;
  localparam logic [7:0] PINCFG_RESET  = 8'h00;
  localparam logic [6:0] PENDING_RESET = 7'h00;
  localparam logic [6:0] MASK_RESET    = 7'h00;

  localparam int TGT_SEL_HI  = 7;
  localparam int TGT_SEL_LO  = 6;
  localparam int TGT_MAIN    = 5;
  localparam int TGT_NODE_HI = 3;
  localparam int TGT_NODE_LO = 0;
  localparam logic [1:0] SEL_SECOND_ADDR = 2'h2;

  localparam int PIN_MSS2   = 6;
  localparam int PIN_MSS0   = 4;
  localparam int PIN_GPIOEN = 3;
  localparam int PIN_SEL_HI = 2;
  localparam int PIN_SEL_LO = 0;

  localparam int IRQ_UNDERFLOW = 6;
  localparam int IRQ_OVERFLOW  = 5;
  localparam int IRQ_INVALID_COMMAND_ERR    = 4;
  localparam int IRQ_TUNNEL    = 3;
  localparam int IRQ_TWOWIRE   = 2;
  localparam int IRQ_REMOTEREG = 1;
  localparam int IRQ_DONE      = 0;
  localparam logic [6:0] MASTER_ONLY_BITS = 7'h06;

  localparam int STAT_BUSY = 0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ---- hw/irq_bank_if.sv ----
// Carries writes and events into the interrupt bank and its state back out.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface irq_bank_if;
  logic       pendWrite;
  logic       maskWrite;
  logic [7:0] wrData;
  logic [6:0] eventSet;
  logic [6:0] pending;
  logic [6:0] mask;

  modport bank (
    input  pendWrite,
    input  maskWrite,
    input  wrData,
    input  eventSet,
    output pending,
    output mask
  );

  modport ctrl (
    output pendWrite,
    output maskWrite,
    output wrData,
    output eventSet,
    input  pending,
    input  mask
  );
endinterface

// ---- hw/irq_bank.sv ----
// Holds the sticky pending interrupt bits and their enable mask.
// Assumes event inputs are one-cycle pulses synchronous to sys_clk.
`timescale 1ns/1ps
module irq_bank (
  input wire logic sys_clk,
  input wire logic rst,
  irq_bank_if.bank bus
);

  logic [6:0] pending_r;
  logic [6:0] pending_nxt;
  logic [6:0] mask_r;
  logic [6:0] clearBits;

  // Write one clears; an event in the same cycle wins over the clear.
  assign clearBits   = bus.pendWrite ? bus.wrData[6:0] : 7'h00;
  assign pending_nxt = (pending_r & ~clearBits) | bus.eventSet;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pending_r <= spi_tunnel_pkg::PENDING_RESET;
    end else begin
      pending_r <= pending_nxt;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mask_r <= spi_tunnel_pkg::MASK_RESET;
    end else if (bus.maskWrite) begin
      mask_r <= bus.wrData[6:0];
    end
  end

  assign bus.pending = pending_r;
  assign bus.mask    = mask_r;

endmodule

// ---- hw/spi_tunnel_ctrl.sv ----
// Register slave for serial peripheral target select, busy pin routing, select enables and interrupts.
// Assumes an AXI4-Lite master on sys_clk and event pulses from the shifting engine.
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
module spi_tunnel_ctrl (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        peripheralBusy,
  input  wire logic        masterMode,
  input  wire logic        queueUnderflowEv,
  input  wire logic        queueOverflowEv,
  input  wire logic        invalidCommandEv,
  input  wire logic        tunnelErrorEv,
  input  wire logic        remoteTwowireEv,
  input  wire logic        remoteRegisterEv,
  input  wire logic        transferDoneEv,
  output logic [1:0]       targetSelect,
  output logic             useSecondAddressPin,
  output logic             mainTargetFlag,
  output logic [3:0]       targetNode,
  output logic [2:0]       masterSelectEnable,
  output logic [7:0]       busyPinOut,
  output logic [7:0]       busyPinOe,
  output logic             spiIrq
);

  // Register index taken from a byte address.
  function automatic logic [7:0] regIndex(input logic [11:0] addr);
    regIndex = addr[9:2];
  endfunction

  // True when the index names a register of this block.
  function automatic logic isMapped(input logic [7:0] idx);
    isMapped = (idx == spi_tunnel_pkg::IDX_STATUS) || (idx == spi_tunnel_pkg::IDX_TARGET) ||
               (idx == spi_tunnel_pkg::IDX_PINCFG) || (idx == spi_tunnel_pkg::IDX_PENDING) ||
               (idx == spi_tunnel_pkg::IDX_IRQMASK);
  endfunction

  // Target register with its unused bit 4 forced to zero.
  function automatic logic [7:0] keepTarget(input logic [7:0] v);
    keepTarget = {v[spi_tunnel_pkg::TGT_SEL_HI:spi_tunnel_pkg::TGT_MAIN], 1'b0,
                  v[spi_tunnel_pkg::TGT_NODE_HI:spi_tunnel_pkg::TGT_NODE_LO]};
  endfunction

  // Pin configuration with its unused top bit forced to zero.
  function automatic logic [7:0] keepPinCfg(input logic [7:0] v);
    keepPinCfg = {1'b0, v[spi_tunnel_pkg::PIN_MSS2:spi_tunnel_pkg::PIN_SEL_LO]};
  endfunction

  irq_bank_if irqBus ();

  irq_bank u_irq_bank (
    .sys_clk (sys_clk),
    .rst     (rst),
    .bus     (irqBus)
  );

  // Write channel state.
  logic        awReady_r;
  logic        awReady_nxt;
  logic        awHeld_r;
  logic        awHeld_nxt;
  logic [7:0]  awIdx_r;
  logic        wReady_r;
  logic        wReady_nxt;
  logic        wHeld_r;
  logic        wHeld_nxt;
  logic [7:0]  wData_r;
  logic        wLane0_r;
  logic        bValid_r;
  logic        bValid_nxt;
  logic [1:0]  bResp_r;
  logic        awTake;
  logic        wTake;
  logic        doWrite;
  logic        writeLow;

  // Read channel state.
  logic        arReady_r;
  logic        arReady_nxt;
  logic        rValid_r;
  logic        rValid_nxt;
  logic [31:0] rData_r;
  logic [1:0]  rResp_r;
  logic        arTake;
  logic [7:0]  arIdx;
  logic [7:0]  readByte;

  // Configuration registers.
  logic [7:0]  target_r;
  logic [7:0]  pinCfg_r;

  // Registered outputs.
  logic [1:0]  targetSelect_r;
  logic        useSecondAddr_r;
  logic        mainTarget_r;
  logic [3:0]  targetNode_r;
  logic [2:0]  masterSelect_r;
  logic [7:0]  busyPinOut_r;
  logic [7:0]  busyPinOe_r;
  logic        irq_r;

  // Derived wires.
  logic        busyToPinEnable;
  logic [2:0]  busyPinChoice;
  logic [7:0]  busyPinOneHot;
  logic [6:0]  rawEvents;
  logic [6:0]  gatedEvents;
  logic        irqLevel;
  logic [7:0]  statusByte;
  logic [7:0]  targetView;
  logic [7:0]  pinCfgView;
  logic [7:0]  pendingView;
  logic [7:0]  maskView;
  logic        wrTarget;
  logic        wrPinCfg;
  logic        wrPending;
  logic        wrMask;
  logic [1:0]  targetSelField;
  logic        secondAddrSel;
  logic [3:0]  nodeEffective;
  logic [2:0]  masterSelField;

  // Write address and data are taken independently, in either order.
  assign awTake   = s_axi_awvalid & awReady_r;
  assign wTake    = s_axi_wvalid & wReady_r;
  assign doWrite  = awHeld_r & wHeld_r & ~bValid_r;
  assign writeLow = doWrite & wLane0_r & isMapped(awIdx_r);

  assign awHeld_nxt  = (awHeld_r | awTake) & ~doWrite;
  assign wHeld_nxt   = (wHeld_r | wTake) & ~doWrite;
  assign bValid_nxt  = doWrite | (bValid_r & ~s_axi_bready);
  assign awReady_nxt = ~awHeld_nxt & ~bValid_nxt;
  assign wReady_nxt  = ~wHeld_nxt & ~bValid_nxt;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      awReady_r <= 1'b0;
      wReady_r  <= 1'b0;
      awHeld_r  <= 1'b0;
      wHeld_r   <= 1'b0;
      bValid_r  <= 1'b0;
    end else begin
      awReady_r <= awReady_nxt;
      wReady_r  <= wReady_nxt;
      awHeld_r  <= awHeld_nxt;
      wHeld_r   <= wHeld_nxt;
      bValid_r  <= bValid_nxt;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      awIdx_r <= 8'h00;
    end else if (awTake) begin
      awIdx_r <= regIndex(s_axi_awaddr);
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wData_r  <= 8'h00;
      wLane0_r <= 1'b0;
    end else if (wTake) begin
      wData_r  <= s_axi_wdata[7:0];
      wLane0_r <= s_axi_wstrb[0];
    end
  end

  // Unmapped addresses answer with a slave error and change nothing.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bResp_r <= spi_tunnel_pkg::RESP_OKAY;
    end else if (doWrite) begin
      bResp_r <= isMapped(awIdx_r) ? spi_tunnel_pkg::RESP_OKAY : spi_tunnel_pkg::RESP_SLVERR;
    end
  end

  // Read address is taken when no answer is outstanding; data follows one cycle later.
  assign arTake      = s_axi_arvalid & arReady_r;
  assign arIdx       = regIndex(s_axi_araddr);
  assign rValid_nxt  = arTake | (rValid_r & ~s_axi_rready);
  assign arReady_nxt = ~rValid_nxt;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      arReady_r <= 1'b0;
      rValid_r  <= 1'b0;
    end else begin
      arReady_r <= arReady_nxt;
      rValid_r  <= rValid_nxt;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rData_r <= 32'h0000_0000;
      rResp_r <= spi_tunnel_pkg::RESP_OKAY;
    end else if (arTake) begin
      rData_r <= {24'h00_0000, readByte};
      rResp_r <= isMapped(arIdx) ? spi_tunnel_pkg::RESP_OKAY : spi_tunnel_pkg::RESP_SLVERR;
    end
  end

  // Status byte shows the live busy flag; other bits read as zero.
  assign statusByte = {7'h00, peripheralBusy};

  // Reserved bits read as zero.
  assign targetView  = keepTarget(target_r);
  assign pinCfgView  = keepPinCfg(pinCfg_r);
  assign pendingView = {1'b0, irqBus.pending};
  assign maskView    = {1'b0, irqBus.mask};

  assign readByte =
    (arIdx == spi_tunnel_pkg::IDX_STATUS)  ? statusByte :
    (arIdx == spi_tunnel_pkg::IDX_TARGET)  ? targetView :
    (arIdx == spi_tunnel_pkg::IDX_PINCFG)  ? pinCfgView :
    (arIdx == spi_tunnel_pkg::IDX_PENDING) ? pendingView :
    (arIdx == spi_tunnel_pkg::IDX_IRQMASK) ? maskView :
    8'h00;

  // One write strobe per writable register (none for status), from the held address.
  assign wrTarget  = writeLow && (awIdx_r == spi_tunnel_pkg::IDX_TARGET);
  assign wrPinCfg  = writeLow && (awIdx_r == spi_tunnel_pkg::IDX_PINCFG);
  assign wrPending = writeLow && (awIdx_r == spi_tunnel_pkg::IDX_PENDING);
  assign wrMask    = writeLow && (awIdx_r == spi_tunnel_pkg::IDX_IRQMASK);

  // Target select register.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      target_r <= spi_tunnel_pkg::TARGET_RESET;
    end else if (wrTarget) begin
      target_r <= keepTarget(wData_r);
    end
  end

  // Pin configuration register.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pinCfg_r <= spi_tunnel_pkg::PINCFG_RESET;
    end else if (wrPinCfg) begin
      pinCfg_r <= keepPinCfg(wData_r);
    end
  end

  // Interrupt bank writes and events.
  assign rawEvents = {queueUnderflowEv, queueOverflowEv, invalidCommandEv, tunnelErrorEv,
                      remoteTwowireEv, remoteRegisterEv, transferDoneEv};
  assign gatedEvents = rawEvents & ~(spi_tunnel_pkg::MASTER_ONLY_BITS & {7{~masterMode}});

  assign irqBus.pendWrite = wrPending;
  assign irqBus.maskWrite = wrMask;
  assign irqBus.wrData    = wData_r;
  assign irqBus.eventSet  = gatedEvents;

  assign irqLevel = |(irqBus.pending & irqBus.mask);

  // Busy pin routing.
  assign busyToPinEnable = pinCfg_r[spi_tunnel_pkg::PIN_GPIOEN];
  assign busyPinChoice   = pinCfg_r[spi_tunnel_pkg::PIN_SEL_HI:spi_tunnel_pkg::PIN_SEL_LO];
  assign busyPinOneHot   = busyToPinEnable ? (8'h01 << busyPinChoice) : 8'h00;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      busyPinOut_r <= 8'h00;
      busyPinOe_r  <= 8'h00;
    end else begin
      busyPinOut_r <= busyPinOneHot & {8{peripheralBusy}};
      busyPinOe_r  <= busyPinOneHot;
    end
  end

  // Steered output values.
  assign targetSelField = target_r[spi_tunnel_pkg::TGT_SEL_HI:spi_tunnel_pkg::TGT_SEL_LO];
  assign secondAddrSel  = (targetSelField == spi_tunnel_pkg::SEL_SECOND_ADDR);
  assign nodeEffective  = target_r[spi_tunnel_pkg::TGT_MAIN] ? 4'h0 :
                          target_r[spi_tunnel_pkg::TGT_NODE_HI:spi_tunnel_pkg::TGT_NODE_LO];
  assign masterSelField = pinCfg_r[spi_tunnel_pkg::PIN_MSS2:spi_tunnel_pkg::PIN_MSS0];

  // Target outputs.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      targetSelect_r  <= 2'h0;
      useSecondAddr_r <= 1'b0;
      mainTarget_r    <= 1'b0;
      targetNode_r    <= 4'h0;
    end else begin
      targetSelect_r  <= targetSelField;
      useSecondAddr_r <= secondAddrSel;
      mainTarget_r    <= target_r[spi_tunnel_pkg::TGT_MAIN];
      targetNode_r    <= nodeEffective;
    end
  end

  // Select enable outputs.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      masterSelect_r <= 3'h0;
    end else begin
      masterSelect_r <= masterSelField;
    end
  end

  // Interrupt request output.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= irqLevel;
    end
  end

  assign s_axi_awready       = awReady_r;
  assign s_axi_wready        = wReady_r;
  assign s_axi_bvalid        = bValid_r;
  assign s_axi_bresp         = bResp_r;
  assign s_axi_arready       = arReady_r;
  assign s_axi_rvalid        = rValid_r;
  assign s_axi_rdata         = rData_r;
  assign s_axi_rresp         = rResp_r;
  assign targetSelect        = targetSelect_r;
  assign useSecondAddressPin = useSecondAddr_r;
  assign mainTargetFlag      = mainTarget_r;
  assign targetNode          = targetNode_r;
  assign masterSelectEnable  = masterSelect_r;
  assign busyPinOut          = busyPinOut_r;
  assign busyPinOe           = busyPinOe_r;
  assign spiIrq              = irq_r;

endmodule

// ---- test/spi_engine_model.sv ----
// Stand-in for the shifting engine that feeds events and the busy level to the register slave.
// Assumes the bench steers it by non-blocking assignments at sys_clk edges.
`timescale 1ns/1ps
module spi_engine_model (
  input  wire logic       sys_clk,
  input  wire logic [6:0] fire,
  input  wire logic       busyReq,
  input  wire logic       masterReq,
  output logic [6:0]      events,
  output logic            peripheralBusy,
  output logic            masterMode
);
  always_ff @(posedge sys_clk) begin
    events         <= fire;
    peripheralBusy <= busyReq;
    masterMode     <= masterReq;
  end
endmodule

// ---- test/spi_tunnel_ctrl_assertions.sv ----
// Checker for the serial peripheral control register slave.
// Assumes it is bound to spi_tunnel_ctrl and sees only its ports.
`timescale 1ns/1ps
module spi_tunnel_ctrl_assertions (
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready,
  input wire logic       s_axi_bvalid,
  input wire logic       peripheralBusy,
  input wire logic       masterMode,
  input wire logic       queueUnderflowEv,
  input wire logic       queueOverflowEv,
  input wire logic       invalidCommandEv,
  input wire logic       tunnelErrorEv,
  input wire logic       remoteTwowireEv,
  input wire logic       remoteRegisterEv,
  input wire logic       transferDoneEv,
  input wire logic [1:0] targetSelect,
  input wire logic       useSecondAddressPin,
  input wire logic       mainTargetFlag,
  input wire logic [3:0] targetNode,
  input wire logic [2:0] masterSelectEnable,
  input wire logic [7:0] busyPinOut,
  input wire logic [7:0] busyPinOe,
  input wire logic       spiIrq
);
  wire evAny = queueUnderflowEv | queueOverflowEv | invalidCommandEv | tunnelErrorEv | transferDoneEv
               | (masterMode & (remoteTwowireEv | remoteRegisterEv));
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence wrTaken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence respAfterOne;
    !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence
  AST_WRITE_RESP: assert property (wrTaken |=> respAfterOne) else $error("Write response mistimed.");
  AST_SEL2: assert property (useSecondAddressPin == (targetSelect == 2'h2)) else $error("Select pin wrong.");
  AST_NODE: assert property (mainTargetFlag |-> targetNode == 4'h0) else $error("Node not ignored.");
  AST_MSS_HOLD: assert property (!$stable(masterSelectEnable) |-> $past(s_axi_bvalid))
    else $error("Select enables moved without write.");
  AST_ONEHOT: assert property ($onehot0(busyPinOe)) else $error("Several busy pins driven.");
  AST_BUSY_PIN: assert property (busyPinOe != 8'h00 |-> busyPinOut == (busyPinOe & {8{$past(peripheralBusy)}}))
    else $error("Busy pin value wrong.");
  AST_IRQ_FALL: assert property ($fell(spiIrq) |-> $past(s_axi_bvalid)) else $error("Interrupt dropped.");
  AST_IRQ_RISE: assert property ($rose(spiIrq) |-> $past(evAny, 2) || $past(s_axi_bvalid))
    else $error("Interrupt without cause.");
endmodule
bind spi_tunnel_ctrl spi_tunnel_ctrl_assertions spi_tunnel_ctrl_assertions_inst (.*);

// ---- test/tb_top.sv ----
// Self-checking bench for the serial peripheral control register slave.
// Assumes the design package is compiled first and the checker is bound.
`timescale 1ns/1ps
module tb_top;
  logic        sys_clk, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic        busyReq, masterReq, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        peripheralBusy, masterMode, useSecondAddressPin, mainTargetFlag, spiIrq;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [6:0]  fire, events;
  logic [1:0]  s_axi_bresp, s_axi_rresp, targetSelect;
  logic [3:0]  targetNode;
  logic [2:0]  masterSelectEnable;
  logic [7:0]  busyPinOut, busyPinOe;
  int          failures, compares;
  logic [7:0]  regIdx [5] = '{spi_tunnel_pkg::IDX_STATUS, spi_tunnel_pkg::IDX_TARGET, spi_tunnel_pkg::IDX_PINCFG,
                              spi_tunnel_pkg::IDX_PENDING, spi_tunnel_pkg::IDX_IRQMASK};

  spi_engine_model spi_engine_model_inst (.*);
  spi_tunnel_ctrl spi_tunnel_ctrl_inst (.*, .s_axi_awprot(3'h0), .s_axi_arprot(3'h0), .s_axi_wstrb(4'hF),
    .queueUnderflowEv(events[6]), .queueOverflowEv(events[5]), .invalidCommandEv(events[4]),
    .tunnelErrorEv(events[3]), .remoteTwowireEv(events[2]), .remoteRegisterEv(events[1]),
    .transferDoneEv(events[0]));

  always #25 sys_clk = ~sys_clk;

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic timeout(input int n);
    if (n >= 100) begin
      failures++;
      conclude();
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge sys_clk);
    s_axi_awaddr  <= {2'b00, idx, 2'b00};
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    timeout(n);
    check("write resp", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask

  task automatic rd(input logic [7:0] idx, input logic [31:0] ed, input logic [1:0] er);
    int n;
    @(posedge sys_clk);
    s_axi_araddr  <= {2'b00, idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    timeout(n);
    check("read data", ed, s_axi_rdata);
    check("read resp", {30'h0, er}, {30'h0, s_axi_rresp});
  endtask

  task automatic pulse(input logic [6:0] v);
    @(posedge sys_clk);
    fire <= v;
    @(posedge sys_clk);
    fire <= 7'h00;
    cyc(3);
  endtask

  initial begin
    {sys_clk, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, busyReq, masterReq} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, fire} = '0;
    rst = 1'b1;
    failures = 0;
    compares = 0;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    cyc(2);
    foreach (regIdx[i]) rd(regIdx[i], 32'h0000_0000, spi_tunnel_pkg::RESP_OKAY);
    rd(8'hB8, 32'h0000_0000, spi_tunnel_pkg::RESP_SLVERR);
    wr(8'hB8, 32'h0000_00FF, spi_tunnel_pkg::RESP_SLVERR);
    for (int s = 0; s < 4; s++) begin
      wr(spi_tunnel_pkg::IDX_TARGET, 32'(s * 64 + s + 8), spi_tunnel_pkg::RESP_OKAY);
      rd(spi_tunnel_pkg::IDX_TARGET, 32'(s * 64 + s + 8), spi_tunnel_pkg::RESP_OKAY);
      check("second pin", 32'(s == 2), {31'h0, useSecondAddressPin});
      check("target node", 32'(s + 8), {28'h0, targetNode});
      check("target select", 32'(s), {30'h0, targetSelect});
      check("main flag", 32'h0, {31'h0, mainTargetFlag});
    end
    wr(spi_tunnel_pkg::IDX_TARGET, 32'h0000_00AF, spi_tunnel_pkg::RESP_OKAY);
    rd(spi_tunnel_pkg::IDX_TARGET, 32'h0000_00AF, spi_tunnel_pkg::RESP_OKAY);
    check("main flag", 32'h1, {31'h0, mainTargetFlag});
    check("node ignored", 32'h0, {28'h0, targetNode});
    busyReq <= 1'b1;
    for (int p = 0; p < 8; p++) begin
      wr(spi_tunnel_pkg::IDX_PINCFG, 32'(8'h78 | p), spi_tunnel_pkg::RESP_OKAY);
      cyc(1);
      check("select enables", 32'h7, {29'h0, masterSelectEnable});
      check("busy pin enable", 32'(1 << p), {24'h0, busyPinOe});
      check("busy pin value", 32'(1 << p), {24'h0, busyPinOut});
    end
    rd(spi_tunnel_pkg::IDX_STATUS, 32'h0000_0001, spi_tunnel_pkg::RESP_OKAY);
    busyReq <= 1'b0;
    cyc(3);
    check("busy pin idle", 32'h0, {24'h0, busyPinOut});
    wr(spi_tunnel_pkg::IDX_PINCFG, 32'h0000_0027, spi_tunnel_pkg::RESP_OKAY);
    rd(spi_tunnel_pkg::IDX_PINCFG, 32'h0000_0027, spi_tunnel_pkg::RESP_OKAY);
    check("select enables", 32'h2, {29'h0, masterSelectEnable});
    check("busy pin off", 32'h0, {24'h0, busyPinOe});
    pulse(7'h7F);
    rd(spi_tunnel_pkg::IDX_PENDING, 32'h0000_0079, spi_tunnel_pkg::RESP_OKAY);
    check("irq masked", 32'h0, {31'h0, spiIrq});
    masterReq <= 1'b1;
    pulse(7'h06);
    rd(spi_tunnel_pkg::IDX_PENDING, 32'h0000_007F, spi_tunnel_pkg::RESP_OKAY);
    for (int b = 0; b < 7; b++) begin
      wr(spi_tunnel_pkg::IDX_IRQMASK, 32'(1 << b), spi_tunnel_pkg::RESP_OKAY);
      rd(spi_tunnel_pkg::IDX_IRQMASK, 32'(1 << b), spi_tunnel_pkg::RESP_OKAY);
      check("irq enabled", 32'h1, {31'h0, spiIrq});
      wr(spi_tunnel_pkg::IDX_PENDING, 32'(1 << b), spi_tunnel_pkg::RESP_OKAY);
      cyc(1);
      check("irq cleared", 32'h0, {31'h0, spiIrq});
      rd(spi_tunnel_pkg::IDX_PENDING, 32'(8'h7F & ~((8'h2 << b) - 8'h1)), spi_tunnel_pkg::RESP_OKAY);
    end
    pulse(7'h40);
    check("irq by event", 32'h1, {31'h0, spiIrq});
    rd(spi_tunnel_pkg::IDX_PENDING, 32'h0000_0040, spi_tunnel_pkg::RESP_OKAY);
    conclude();
  end
endmodule
